// ===== hw/timer_map.svh
// register offsets, field positions, reset values of the timer channel
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH
`define ADDR_MODE_CTL      4'h0
`define ADDR_CAPCMP_CTL    4'h1
`define ADDR_OUT_CTL       4'h2
`define ADDR_PRESCALE_SEL  4'h3
`define ADDR_COUNT_REG     4'h4
`define ADDR_CMP_CAP_A     4'h5
`define ADDR_CMP_CAP_B     4'h6
`define ADDR_IRQ_STATUS    4'h7
`define ADDR_IRQ_MASK      4'h8
`define MODE_OVF_BIT       0
`define MODE_INV_EDGE_BIT  1
`define CC_A_CAPTURE_BIT   0
`define CC_A_SRC_BIT       1
`define CC_B_CAPTURE_BIT   2
`define OC_DRIVE_BIT       0
`define OC_INV_A_BIT       1
`define OC_LVL_CLR_BIT     2
`define OC_LVL_SET_BIT     3
`define OC_INV_B_BIT       4
`define OC_OS_ENABLE_BIT   5
`define OC_OS_FIRE_BIT     6
`define COUNT_MAX          16'hFFFF
`define COUNT_ZERO         16'h0000
`define RESET_BYTE         8'h00
`define RESET_WORD         16'h0000
`endif

// ===== hw/timer_pkg.sv
// types of the timer channel
package timer_pkg;
   typedef enum logic [1:0] {
      MODE_STOP    = 2'h0,
      MODE_FREE    = 2'h1,
      MODE_RESTART = 2'h2,
      MODE_MATCHCL = 2'h3
   } op_mode_t;
   typedef enum logic [1:0] {
      EDGE_FALL = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_NONE = 2'h2,
      EDGE_BOTH = 2'h3
   } edge_sel_t;
endpackage : timer_pkg

// ===== hw/oneshot_and_pulse_width_timer.sv
// 16-bit one-shot pulse and pulse-width capture timer channel
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "timer_map.svh"

// Notes on behaviour
// RL1: match A raises irq A, inverts output
// RL2: match B raises irq B, inverts output
// RL3: software keeps compare A and B different
// RL4: output active after M+1, for N-M clocks
// RL5: fire bit or A edge restarts, one pulse
// RL6: free-run and restart measurement both supported
// RL7: free-run: B edge to A, A edge to B
// RL8: software selects both edges for two inputs
// RL9: software saves earlier captures for subtraction
// RL10: single input: reverse edge A, valid B
// RL11: restart mode: valid edge captures, clears counter
// RL12: software adds 10000H after overflow, clears flag
// RL13: overflow flag sticky until written zero
// RL14: software reads loaded capture on interrupt
// RL15: capture A source is input A or B
// RL16: capture B triggers only from input A
// RL17: counter read never disturbs counting
// RL18: wrap FFFF to 0000 sets overflow
// RL19: inputs synchronised; load and irq together
module oneshot_and_pulse_width_timer (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wrData,
   input  wire logic        wrStrobe,
   input  wire logic        rdStrobe,
   output logic      [15:0] rdData,
   input  wire logic        trigInA,
   input  wire logic        trigInB,
   output logic             timerOut,
   output logic             timerOutEn,
   output logic             matchIrqA,
   output logic             matchIrqB,
   output logic             irq
);
   logic [7:0]  modeCtl;
   logic [7:0]  capcmpCtl;
   logic [7:0]  outCtl;
   logic [7:0]  prescaleSel;
   logic [15:0] count;
   logic [15:0] cmpCapA;
   logic [15:0] cmpCapB;
   logic [1:0]  irqStat;
   logic [1:0]  irqMask;
   logic [5:0]  pre;
   logic        oneshotBusy;
   logic [2:0]  syncA;
   logic [2:0]  syncB;
   logic [1:0]  level;
   logic [1:0]  rise;
   logic [1:0]  fall;
   logic        tick;
   logic        fire;
   logic        running;
   logic        validA;
   logic        reverseA;
   logic        validB;
   logic        restart;
   logic        wrap;
   logic        hitA;
   logic        hitB;
   logic        capAEvt;
   logic        capBEvt;
   logic        irqAEvt;
   logic        irqBEvt;
   logic        invA;
   logic        invB;
   logic [15:0] next_count;
   logic [1:0]  next_irqStat;
   timer_pkg::op_mode_t  opMode;
   timer_pkg::edge_sel_t edgeA;
   timer_pkg::edge_sel_t edgeB;

   assign opMode  = timer_pkg::op_mode_t'(modeCtl[3:2]);
   assign edgeA   = timer_pkg::edge_sel_t'(prescaleSel[5:4]);
   assign edgeB   = timer_pkg::edge_sel_t'(prescaleSel[7:6]);
   assign running = opMode != timer_pkg::MODE_STOP;

   // three-stage synchronisers; stage one feeds only stage two
   always_ff @(posedge clk) begin
      if (rst) begin
         syncA <= 3'h0;
         syncB <= 3'h0;
      end else begin
         syncA <= {syncA[1:0], trigInA};
         syncB <= {syncB[1:0], trigInB};
      end
   end

   // a change counts once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_edge
         logic s2;
         logic s3;
         assign s2       = (gi == 0) ? syncA[1] : syncB[1];
         assign s3       = (gi == 0) ? syncA[2] : syncB[2];
         assign rise[gi] = (s2 == s3) && s3 && !level[gi]; // RL19
         assign fall[gi] = (s2 == s3) && !s3 && level[gi]; // RL19
         always_ff @(posedge clk) begin
            if (rst) begin
               level[gi] <= 1'b0;
            end else if (s2 == s3) begin
               level[gi] <= s3;
            end
         end
      end
   endgenerate

   function automatic logic edge_hit(timer_pkg::edge_sel_t sel, logic r, logic f);
      unique case (sel)
         timer_pkg::EDGE_FALL: edge_hit = f;
         timer_pkg::EDGE_RISE: edge_hit = r;
         timer_pkg::EDGE_BOTH: edge_hit = r | f;
         timer_pkg::EDGE_NONE: edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   assign validA   = running && edge_hit(edgeA, rise[0], fall[0]);
   assign validB   = running && edge_hit(edgeB, rise[1], fall[1]);
   // both-edge selection leaves no reverse phase
   assign reverseA = running && (edgeA == timer_pkg::EDGE_FALL ? rise[0] :
                                 edgeA == timer_pkg::EDGE_RISE ? fall[0] : 1'b0);

   // count clock prescaler: clk/1, /4, /16, /64
   always_ff @(posedge clk) begin
      if (rst) begin
         pre <= 6'h00;
      end else begin
         pre <= pre + 6'h01;
      end
   end

   always_comb begin
      unique case (prescaleSel[1:0])
         2'h0: tick = 1'b1;
         2'h1: tick = &pre[1:0];
         2'h2: tick = &pre[3:0];
         2'h3: tick = &pre;
      endcase
   end

   assign fire    = wrStrobe && addr == `ADDR_OUT_CTL && wrData[`OC_OS_FIRE_BIT];
   // one-shot trigger from the fire bit or a valid input A edge
   assign restart = running && outCtl[`OC_OS_ENABLE_BIT] && (fire || validA)  // RL5
                 || opMode == timer_pkg::MODE_RESTART && validA;              // RL11
   assign wrap    = running && tick && count == `COUNT_MAX && !restart;

   always_comb begin
      next_count = count;
      if (!running) begin
         next_count = `COUNT_ZERO;
      end else if (restart) begin
         next_count = `COUNT_ZERO; // RL5
      end else if (opMode == timer_pkg::MODE_MATCHCL && tick && count == cmpCapA) begin
         next_count = `COUNT_ZERO;
      end else if (tick) begin
         next_count = count + 16'h0001;
      end
   end

   // counter is a plain register, reads only sample it
   always_ff @(posedge clk) begin
      if (rst) begin
         count <= `COUNT_ZERO;
      end else begin
         count <= next_count; // RL17
      end
   end

   // matches are taken when the counter moves onto the compare value
   assign hitA = running && !capcmpCtl[`CC_A_CAPTURE_BIT] && next_count != count
              && next_count == cmpCapA;
   assign hitB = running && !capcmpCtl[`CC_B_CAPTURE_BIT] && next_count != count
              && next_count == cmpCapB;

   assign capAEvt = capcmpCtl[`CC_A_CAPTURE_BIT]
                 && (capcmpCtl[`CC_A_SRC_BIT] ? reverseA : validB); // RL15 RL7 RL10 RL11
   assign capBEvt = capcmpCtl[`CC_B_CAPTURE_BIT] && validA;        // RL16 RL7 RL10 RL11
   // reverse-phase captures raise no interrupt
   assign irqAEvt = hitA || capAEvt && !capcmpCtl[`CC_A_SRC_BIT];   // RL1 RL19
   assign irqBEvt = hitB || capBEvt;                                // RL2 RL19

   // capture wins over a software write in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         cmpCapA <= `RESET_WORD;
      end else if (capAEvt) begin
         cmpCapA <= count;
      end else if (wrStrobe && addr == `ADDR_CMP_CAP_A) begin
         cmpCapA <= wrData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmpCapB <= `RESET_WORD;
      end else if (capBEvt) begin
         cmpCapB <= count;
      end else if (wrStrobe && addr == `ADDR_CMP_CAP_B) begin
         cmpCapB <= wrData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         matchIrqA <= 1'b0;
         matchIrqB <= 1'b0;
      end else begin
         matchIrqA <= irqAEvt; // RL1
         matchIrqB <= irqBEvt; // RL2
      end
   end

   // overflow flag: hardware set beats a software clear
   always_ff @(posedge clk) begin
      if (rst) begin
         modeCtl <= `RESET_BYTE;
      end else begin
         if (wrStrobe && addr == `ADDR_MODE_CTL) begin
            modeCtl[7:1] <= wrData[7:1];
            if (!wrData[`MODE_OVF_BIT]) begin
               modeCtl[`MODE_OVF_BIT] <= 1'b0; // RL13
            end
         end
         if (wrap) begin
            modeCtl[`MODE_OVF_BIT] <= 1'b1; // RL18
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         capcmpCtl   <= `RESET_BYTE;
         prescaleSel <= `RESET_BYTE;
         irqMask     <= 2'h0;
      end else if (wrStrobe) begin
         if (addr == `ADDR_CAPCMP_CTL) begin
            capcmpCtl <= wrData[7:0];
         end
         if (addr == `ADDR_PRESCALE_SEL) begin
            prescaleSel <= wrData[7:0];
         end
         if (addr == `ADDR_IRQ_MASK) begin
            irqMask <= wrData[1:0];
         end
      end
   end

   // fire and level bits are strobes, never stored
   always_ff @(posedge clk) begin
      if (rst) begin
         outCtl <= `RESET_BYTE;
      end else if (wrStrobe && addr == `ADDR_OUT_CTL) begin
         outCtl <= wrData[7:0] & 8'h33;
      end
   end

   // one pulse per trigger: a retrigger while busy clears the counter to zero and keeps busy set
   always_ff @(posedge clk) begin
      if (rst || !running || !outCtl[`OC_OS_ENABLE_BIT]) begin
         oneshotBusy <= 1'b0;
      end else if (hitB) begin
         oneshotBusy <= 1'b0;
      end else if (restart) begin
         oneshotBusy <= 1'b1; // RL5
      end
   end

   assign invA = hitA && outCtl[`OC_INV_A_BIT]
              && (!outCtl[`OC_OS_ENABLE_BIT] || oneshotBusy)
              || validA && modeCtl[`MODE_INV_EDGE_BIT]
              && capcmpCtl[`CC_A_CAPTURE_BIT] && capcmpCtl[`CC_B_CAPTURE_BIT];
   assign invB = hitB && outCtl[`OC_INV_B_BIT]
              && (!outCtl[`OC_OS_ENABLE_BIT] || oneshotBusy);

   always_ff @(posedge clk) begin
      if (rst) begin
         timerOut <= 1'b0;
      end else if (!running && wrStrobe && addr == `ADDR_OUT_CTL
                   && wrData[`OC_LVL_SET_BIT] != wrData[`OC_LVL_CLR_BIT]) begin
         timerOut <= wrData[`OC_LVL_SET_BIT];
      end else if (invA ^ invB) begin
         timerOut <= !timerOut; // RL1 RL2 RL4
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         timerOutEn <= 1'b0;
      end else begin
         timerOutEn <= outCtl[`OC_DRIVE_BIT];
      end
   end

   always_comb begin
      next_irqStat = irqStat;
      if (wrStrobe && addr == `ADDR_IRQ_STATUS) begin
         next_irqStat = irqStat & ~wrData[1:0];
      end
      next_irqStat = next_irqStat | {irqBEvt, irqAEvt};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irqStat <= 2'h0;
         irq     <= 1'b0;
      end else begin
         irqStat <= next_irqStat;
         irq     <= |(irqStat & irqMask);
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !rdStrobe) begin
         rdData <= `RESET_WORD;
      end else begin
         unique case (addr)
            `ADDR_MODE_CTL:     rdData <= {8'h00, modeCtl};
            `ADDR_CAPCMP_CTL:   rdData <= {8'h00, capcmpCtl};
            `ADDR_OUT_CTL:      rdData <= {8'h00, outCtl};
            `ADDR_PRESCALE_SEL: rdData <= {8'h00, prescaleSel};
            `ADDR_COUNT_REG:    rdData <= count; // RL17
            `ADDR_CMP_CAP_A:    rdData <= cmpCapA;
            `ADDR_CMP_CAP_B:    rdData <= cmpCapB;
            `ADDR_IRQ_STATUS:   rdData <= {14'h0000, irqStat};
            `ADDR_IRQ_MASK:     rdData <= {14'h0000, irqMask};
            default:            rdData <= `RESET_WORD;
         endcase
      end
   end

   ovf_set_a: assert property (@(posedge clk) disable iff (rst)
      wrap |=> modeCtl[`MODE_OVF_BIT]) // RL18
      else $error("overflow flag missed a wrap");
   ovf_sticky_a: assert property (@(posedge clk) disable iff (rst)
      modeCtl[`MODE_OVF_BIT] && !(wrStrobe && addr == `ADDR_MODE_CTL)
      |=> modeCtl[`MODE_OVF_BIT]) // RL13
      else $error("overflow flag dropped without a write");
   restart_clear_a: assert property (@(posedge clk) disable iff (rst)
      opMode == timer_pkg::MODE_RESTART && validA |=> count == `COUNT_ZERO) // RL11
      else $error("restart edge did not clear the counter");
   cap_b_load_a: assert property (@(posedge clk) disable iff (rst)
      capBEvt |=> cmpCapB == $past(count) && matchIrqB) // RL16
      else $error("capture B load or interrupt wrong");
   cap_a_from_b_a: assert property (@(posedge clk) disable iff (rst)
      validB && capcmpCtl[`CC_A_CAPTURE_BIT] && !capcmpCtl[`CC_A_SRC_BIT]
      |=> cmpCapA == $past(count) && matchIrqA) // RL7
      else $error("input B edge did not load capture A");
   cap_a_reverse_a: assert property (@(posedge clk) disable iff (rst)
      reverseA && capcmpCtl[`CC_A_CAPTURE_BIT] && capcmpCtl[`CC_A_SRC_BIT]
      |=> cmpCapA == $past(count, 1)) // RL10
      else $error("reverse edge did not load capture A");
   match_toggle_a: assert property (@(posedge clk) disable iff (rst)
      hitA && oneshotBusy && outCtl[`OC_INV_A_BIT] && !invB && !validA
      |=> matchIrqA && timerOut != $past(timerOut)) // RL1
      else $error("match A did not invert the output");
   match_b_end_a: assert property (@(posedge clk) disable iff (rst)
      hitB && oneshotBusy |=> !oneshotBusy) // RL5
      else $error("one-shot did not end on match B");
   stopped_zero_a: assert property (@(posedge clk) disable iff (rst)
      !running |=> count == `COUNT_ZERO) // RL6
      else $error("stopped counter not held at zero");
   count_step_a: assert property (@(posedge clk) disable iff (rst)
      opMode == timer_pkg::MODE_FREE && $past(opMode) == timer_pkg::MODE_FREE
      && !restart && tick && count != `COUNT_MAX
      |=> count == $past(count) + 16'h0001) // RL17
      else $error("counter did not advance");
   read_slot_a: assert property (@(posedge clk) disable iff (rst)
      !$past(rdStrobe) |-> rdData == `RESET_WORD)
      else $error("read data outside its slot");
endmodule : oneshot_and_pulse_width_timer

// ===== bench/trig_pins.sv
// pulse source model driving the two trigger pins
`timescale 1ns/1ps
module trig_pins (
   input  wire logic clk,
   output logic      trigInA,
   output logic      trigInB
);
   initial begin
      trigInA = 1'b0;
      trigInB = 1'b0;
   end
   // change just after an edge, then hold so the synchroniser sees every level
   task automatic drive(input logic ch, input logic lvl, input int hold);
      @(posedge clk);
      if (ch) trigInB <= lvl;
      else trigInA <= lvl;
      repeat (hold) @(posedge clk);
   endtask : drive
endmodule : trig_pins

// ===== bench/tb.sv
// self-checking bench for the one-shot and capture timer channel
`timescale 1ns/1ps
`include "timer_map.svh"
module tb;
   logic        clk, rst, wrStrobe, rdStrobe, trigInA, trigInB;
   logic [3:0]  addr;
   logic [15:0] wrData, rdData, v, capA, capB;
   logic        timerOut, timerOutEn, matchIrqA, matchIrqB, irq, irqRise, irqFall, prev;
   int          failures = 0;
   int          n_tests  = 0;
   int          rise, fall, pulses;

   oneshot_and_pulse_width_timer uut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
      .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .trigInA(trigInA),
      .trigInB(trigInB), .timerOut(timerOut), .timerOutEn(timerOutEn),
      .matchIrqA(matchIrqA), .matchIrqB(matchIrqB), .irq(irq));
   trig_pins pins (.clk(clk), .trigInA(trigInA), .trigInB(trigInB));

   always #20 clk = ~clk;

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      @(posedge clk);
      wrStrobe <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
      #1 v = rdData;
   endtask : rd

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic rc(input logic [3:0] a, input logic [15:0] e, input string nm);
      rd(a);
      chk(nm, v, e);
   endtask : rc

   // watch one output pulse; a second rise inside the window would be a retrigger fault
   task automatic oneShot(input logic viaPin);
      rise = -1;
      fall = -1;
      pulses = 0;
      prev = 1'b0;
      if (viaPin) pins.drive(1'b0, 1'b1, 2);
      else wr(`ADDR_OUT_CTL, 16'h0073);
      for (int i = 1; i < 200; i++) begin
         @(posedge clk);
         #1;
         if (timerOut === 1'b1 && prev === 1'b0) begin
            pulses++;
            if (rise < 0) begin
               rise = i;
               irqRise = matchIrqA;
            end
         end
         if (timerOut === 1'b0 && prev === 1'b1) begin
            fall = i;
            irqFall = matchIrqB;
         end
         prev = timerOut;
      end
      chk("pulse count", 16'(pulses), 16'h0001);
      chk("pulse width", 16'(fall - rise), 16'h001E);
      chk("irq a at set", {15'h0, irqRise}, 16'h0001);
      chk("irq b at clear", {15'h0, irqFall}, 16'h0001);
      chk("drive enable", {15'h0, timerOutEn}, 16'h0001);
   endtask : oneShot

   task test_done;
      $display("failures %0d n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   // whole run is about 67000 cycles, the overflow wait being most of it
   initial begin
      #(40 * 80000);
      failures++;
      test_done();
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      addr = 4'h0;
      wrData = 16'h0000;
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++) rc(4'(i), 16'h0000, "reset value");
      rc(4'hF, 16'h0000, "unmapped");
      wr(`ADDR_OUT_CTL, 16'h0009);
      rc(`ADDR_OUT_CTL, 16'h0001, "strobe bits");
      chk("level set", {15'h0, timerOut}, 16'h0001);
      wr(`ADDR_OUT_CTL, 16'h0005);
      #1 chk("level clear", {15'h0, timerOut}, 16'h0000);
      wr(`ADDR_COUNT_REG, 16'h1234);
      rc(`ADDR_COUNT_REG, 16'h0000, "count read only");
      // one-shot, fired by software then by a rising edge on input a
      wr(`ADDR_PRESCALE_SEL, 16'h0010);
      wr(`ADDR_CMP_CAP_A, 16'h0014);
      wr(`ADDR_CMP_CAP_B, 16'h0032);
      wr(`ADDR_MODE_CTL, 16'h0004);
      wr(`ADDR_OUT_CTL, 16'h0033);
      oneShot(1'b0);
      // loop index starts one clock after the fire strobe cycle
      chk("pulse delay", 16'(rise + 1), 16'h0015);
      oneShot(1'b1);
      wr(`ADDR_OUT_CTL, 16'h0000);
      wr(`ADDR_IRQ_STATUS, 16'h0003);
      // two-input measurement, free running, both edges on both pins
      wr(`ADDR_PRESCALE_SEL, 16'h00F0);
      wr(`ADDR_CAPCMP_CTL, 16'h0005);
      wr(`ADDR_IRQ_MASK, 16'h0003);
      pins.drive(1'b1, 1'b1, 10);
      pins.drive(1'b0, 1'b0, 8);
      rd(`ADDR_CMP_CAP_A);
      capA = v;
      rd(`ADDR_CMP_CAP_B);
      capB = v;
      chk("b edge to a, a edge to b", capB - capA, 16'h000B);
      rc(`ADDR_IRQ_STATUS, 16'h0003, "capture status");
      chk("irq level", {15'h0, irq}, 16'h0001);
      wr(`ADDR_IRQ_STATUS, 16'h0003);
      rc(`ADDR_IRQ_STATUS, 16'h0000, "status cleared");
      chk("irq cleared", {15'h0, irq}, 16'h0000);
      wr(`ADDR_IRQ_MASK, 16'h0000);
      pins.drive(1'b1, 1'b0, 8);
      rc(`ADDR_IRQ_STATUS, 16'h0001, "masked status");
      chk("irq masked", {15'h0, irq}, 16'h0000);
      wr(`ADDR_IRQ_STATUS, 16'h0003);
      // single input, free running: reverse edge to a, valid edge to b
      wr(`ADDR_MODE_CTL, 16'h0006);
      wr(`ADDR_PRESCALE_SEL, 16'h0090);
      wr(`ADDR_CAPCMP_CTL, 16'h0007);
      pins.drive(1'b0, 1'b1, 12);
      pins.drive(1'b0, 1'b0, 8);
      rd(`ADDR_CMP_CAP_A);
      capA = v;
      rd(`ADDR_CMP_CAP_B);
      chk("high width", capA - v, 16'h000D);
      chk("edge invert", {15'h0, timerOut}, 16'h0001);
      rc(`ADDR_IRQ_STATUS, 16'h0002, "reverse edge no irq");
      // restart on the valid edge of input a
      wr(`ADDR_MODE_CTL, 16'h0008);
      pins.drive(1'b0, 1'b1, 15);
      pins.drive(1'b0, 1'b0, 9);
      pins.drive(1'b0, 1'b1, 8);
      rc(`ADDR_CMP_CAP_A, 16'h000F, "restart high width");
      rc(`ADDR_CMP_CAP_B, 16'h0019, "restart period");
      // free running long enough to wrap once
      wr(`ADDR_MODE_CTL, 16'h0004);
      rd(`ADDR_COUNT_REG);
      capA = v;
      rd(`ADDR_COUNT_REG);
      chk("count runs on", v - capA, 16'h0002);
      repeat (66000) @(posedge clk);
      rc(`ADDR_MODE_CTL, 16'h0005, "overflow set");
      wr(`ADDR_MODE_CTL, 16'h0005);
      rc(`ADDR_MODE_CTL, 16'h0005, "overflow kept");
      wr(`ADDR_MODE_CTL, 16'h0004);
      rc(`ADDR_MODE_CTL, 16'h0004, "overflow cleared");
      // count clock divided by four: 40 clocks give exactly ten counts
      wr(`ADDR_PRESCALE_SEL, 16'h0091);
      rd(`ADDR_COUNT_REG);
      capA = v;
      repeat (38) @(posedge clk);
      rd(`ADDR_COUNT_REG);
      chk("divided count", v - capA, 16'h000A);
      // clear on compare a match; stop first so the count starts below it
      wr(`ADDR_CAPCMP_CTL, 16'h0000);
      wr(`ADDR_CMP_CAP_A, 16'h0003);
      wr(`ADDR_MODE_CTL, 16'h0000);
      wr(`ADDR_MODE_CTL, 16'h000C);
      repeat (30) @(posedge clk);
      rd(`ADDR_COUNT_REG);
      chk("match clear", {15'h0, v <= 16'h0003}, 16'h0001);
      test_done();
   end
endmodule : tb
